// ===== hdl/cpr_core_state.sv
/*
 * Programmer-visible state of the 8-bit core: accumulator, pointer and
 * short-direct registers on the data-space port, 12-bit program
 * counter with its update sources, return stack and three flag banks.
 * Assumes the instruction sequencer drives the one-cycle op strobes only
 * in the clock before O_MC_TICK rises (a one-clock delayed copy of the divider tick) and decodes instructions itself.
 */
`timescale 1ns/1ns
module cpr_core_state (
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// Data-space port
	input wire logic [7:0] I_DS_ADDR,
	input wire logic I_DS_WR,
	input wire logic [7:0] I_DS_WDATA,
	output logic [7:0] O_DS_RDATA,
	output logic O_DS_HIT,
	// Program counter control
	input wire logic I_PC_STEP,
	input wire cpr_pkg::cpr_pc_op_t I_PC_OP,
	input wire logic [11:0] I_PC_TARGET,
	input wire logic [11:0] I_PC_VECTOR,
	input wire logic [7:0] I_PC_OFFSET,
	input wire logic I_PC_BACKWARD,
	input wire logic [11:0] I_RESET_VECTOR_DATA,
	// Flag update from the ALU
	input wire logic [1:0] I_FLG_OP,
	input wire logic I_FLG_CARRY,
	input wire logic [7:0] I_FLG_RESULT,
	// State outputs
	output logic [11:0] O_PC,
	output logic [7:0] O_ACCUM,
	output logic O_CARRY,
	output logic O_ZERO,
	output cpr_pkg::cpr_ctx_t O_CTX,
	output logic O_MC_TICK,
	output logic O_IN_RESET_FETCH
);
	import cpr_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] accum_r;
		logic [7:0] ptr_first_r;
		logic [7:0] ptr_second_r;
		logic [7:0] sd_first_r;
		logic [7:0] sd_second_r;
		logic [11:0] pc_r;
		logic boot_r;
		cpr_ctx_t ctx_r;
		cpr_ctx_t ctx_prev_r;
		cpr_ctx_t ctx_main_save_r;
		logic [2:0] carry_r;
		logic [2:0] zero_r;
		logic carry_act_r;
		logic zero_act_r;
		logic [7:0] rdata_r;
		logic hit_r;
	} cpr_core_st_t;

	cpr_core_st_t st_r;
	cpr_core_st_t st_nxt;

	logic mc_tick;
	logic push;
	logic pop;
	logic [11:0] stack_top;
	logic stack_empty;
	logic [11:0] branch_sum;
	logic [7:0] ds_read;

	// Bank index for a one-hot context
	function automatic logic [1:0] bank_of(input cpr_ctx_t c);
		case (c)
			CPR_CTX_MAIN: bank_of = 2'h0;
			CPR_CTX_IRQ: bank_of = 2'h1;
			CPR_CTX_NMI: bank_of = 2'h2;
			default: bank_of = 2'h0;
		endcase
	endfunction : bank_of

	// Data-space address decode, used only for the hit flag
	function automatic logic ds_mapped(input logic [7:0] a);
		ds_mapped = (a == CPR_ADDR_PTR_FIRST) || (a == CPR_ADDR_PTR_SECOND) ||
			(a == CPR_ADDR_SD_FIRST) || (a == CPR_ADDR_SD_SECOND) ||
			(a == CPR_ADDR_ACCUM);
	endfunction : ds_mapped

	// ****************************************************************
	// Submodules
	// ****************************************************************
	cpr_mc_div u_div (
		.i_clk(I_CLOCK),
		.i_rst(I_RESET),
		.o_tick(mc_tick)
	);

	// Stack moves only on machine-cycle ticks
	assign push = I_PC_STEP && mc_tick && ((I_PC_OP == CPR_PC_CALL) ||
		(I_PC_OP == CPR_PC_IRQ) || (I_PC_OP == CPR_PC_NMI));
	assign pop = I_PC_STEP && mc_tick && ((I_PC_OP == CPR_PC_SUB_EXIT) ||
		(I_PC_OP == CPR_PC_INT_EXIT));

	cpr_ret_stack u_stack (
		.i_clk(I_CLOCK),
		.i_rst(I_RESET),
		.i_push(push),
		.i_pop(pop),
		.i_data(st_r.pc_r),
		.o_top(stack_top),
		.o_empty(stack_empty)
	);

	// ****************************************************************
	// Relative branch adder
	// ****************************************************************
	// Offset is magnitude plus direction; the sum wraps in 4 KB
	always_comb begin
		if (I_PC_BACKWARD) begin
			branch_sum = st_r.pc_r - {4'h0, I_PC_OFFSET};
		end else begin
			branch_sum = st_r.pc_r + {4'h0, I_PC_OFFSET};
		end
	end

	// ****************************************************************
	// Data-space read mux
	// ****************************************************************
	always_comb begin
		case (I_DS_ADDR)
			CPR_ADDR_PTR_FIRST: ds_read = st_r.ptr_first_r;
			CPR_ADDR_PTR_SECOND: ds_read = st_r.ptr_second_r;
			CPR_ADDR_SD_FIRST: ds_read = st_r.sd_first_r;
			CPR_ADDR_SD_SECOND: ds_read = st_r.sd_second_r;
			CPR_ADDR_ACCUM: ds_read = st_r.accum_r;
			default: ds_read = 8'h00;
		endcase
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata_r = ds_read;
		st_nxt.hit_r = ds_mapped(I_DS_ADDR);

		// Register writes; bit-direct ops arrive as read-modify-write
		if (I_DS_WR) begin
			case (I_DS_ADDR)
				CPR_ADDR_PTR_FIRST: st_nxt.ptr_first_r = I_DS_WDATA;
				CPR_ADDR_PTR_SECOND: st_nxt.ptr_second_r = I_DS_WDATA;
				CPR_ADDR_SD_FIRST: st_nxt.sd_first_r = I_DS_WDATA;
				CPR_ADDR_SD_SECOND: st_nxt.sd_second_r = I_DS_WDATA;
				CPR_ADDR_ACCUM: st_nxt.accum_r = I_DS_WDATA;
				default: st_nxt.accum_r = st_r.accum_r;
			endcase
		end

		// First tick after reset fetches the reset vector contents
		if (st_r.boot_r) begin
			if (mc_tick) begin
				st_nxt.pc_r = I_RESET_VECTOR_DATA;
				st_nxt.boot_r = 1'b0;
			end
		end else if (I_PC_STEP && mc_tick) begin
			// One step per instruction phase; length set by sequencer
			case (I_PC_OP)
				CPR_PC_NEXT: begin
					st_nxt.pc_r = st_r.pc_r + 12'h001;
				end
				CPR_PC_JUMP: begin
					st_nxt.pc_r = I_PC_TARGET;
				end
				CPR_PC_CALL: begin
					st_nxt.pc_r = I_PC_TARGET;
				end
				CPR_PC_BRANCH: begin
					st_nxt.pc_r = branch_sum;
				end
				CPR_PC_IRQ: begin
					st_nxt.pc_r = I_PC_VECTOR;
					st_nxt.ctx_prev_r = st_r.ctx_r;
					st_nxt.ctx_r = CPR_CTX_IRQ;
					if (st_r.ctx_r == CPR_CTX_MAIN) begin
						st_nxt.ctx_main_save_r = CPR_CTX_MAIN;
					end
				end
				CPR_PC_NMI: begin
					st_nxt.pc_r = I_PC_VECTOR;
					st_nxt.ctx_prev_r = st_r.ctx_r;
					st_nxt.ctx_r = CPR_CTX_NMI;
				end
				CPR_PC_SUB_EXIT: begin
					// Empty stack: fall through to next instruction
					if (stack_empty) begin
						st_nxt.pc_r = st_r.pc_r + 12'h001;
					end else begin
						st_nxt.pc_r = stack_top;
					end
				end
				CPR_PC_INT_EXIT: begin
					if (stack_empty) begin
						st_nxt.pc_r = st_r.pc_r + 12'h001;
					end else begin
						st_nxt.pc_r = stack_top;
					end
					// Restore the pair in use before entry
					st_nxt.ctx_r = st_r.ctx_prev_r;
					// An nmi nested in irq returns to irq, which returns to main afterwards
					if (st_r.ctx_r == CPR_CTX_NMI &&
						st_r.ctx_prev_r == CPR_CTX_IRQ) begin
						st_nxt.ctx_prev_r = st_r.ctx_main_save_r;
					end else begin
						st_nxt.ctx_prev_r = CPR_CTX_MAIN;
					end
				end
				default: st_nxt.pc_r = st_r.pc_r;
			endcase
		end

		// Only the active bank is touched; others keep their values
		case (I_FLG_OP)
			CPR_FLG_ARITH: begin
				st_nxt.carry_r[bank_of(st_r.ctx_r)] = I_FLG_CARRY;
				st_nxt.zero_r[bank_of(st_r.ctx_r)] =
					(I_FLG_RESULT == 8'h00);
			end
			CPR_FLG_LOGIC: begin
				st_nxt.zero_r[bank_of(st_r.ctx_r)] =
					(I_FLG_RESULT == 8'h00);
			end
			CPR_FLG_CARRY: begin
				// Bit test or rotate: carry only
				st_nxt.carry_r[bank_of(st_r.ctx_r)] = I_FLG_CARRY;
			end
			default: st_nxt.carry_r = st_r.carry_r;
		endcase

		// Active pair registered so the flag outputs come from flip-flops
		st_nxt.carry_act_r = st_nxt.carry_r[bank_of(st_nxt.ctx_r)];
		st_nxt.zero_act_r = st_nxt.zero_r[bank_of(st_nxt.ctx_r)];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset lands in non-maskable context so init cannot be interrupted
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			st_r.accum_r <= CPR_REG_RESET;
			st_r.ptr_first_r <= CPR_REG_RESET;
			st_r.ptr_second_r <= CPR_REG_RESET;
			st_r.sd_first_r <= CPR_REG_RESET;
			st_r.sd_second_r <= CPR_REG_RESET;
			st_r.pc_r <= CPR_RESET_VECTOR;
			st_r.boot_r <= 1'b1;
			st_r.ctx_r <= CPR_CTX_NMI;
			st_r.ctx_prev_r <= CPR_CTX_MAIN;
			st_r.ctx_main_save_r <= CPR_CTX_MAIN;
			st_r.carry_r <= 3'h0;
			st_r.zero_r <= 3'h0;
			st_r.carry_act_r <= 1'b0;
			st_r.zero_act_r <= 1'b0;
			st_r.rdata_r <= 8'h00;
			st_r.hit_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs, all straight from flip-flops
	// ****************************************************************
	logic mc_tick_r;

	// Delayed copy keeps the tick output registered at top level
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			mc_tick_r <= 1'b0;
		end else begin
			mc_tick_r <= mc_tick;
		end
	end

	assign O_DS_RDATA = st_r.rdata_r;
	assign O_DS_HIT = st_r.hit_r;
	assign O_PC = st_r.pc_r;
	assign O_ACCUM = st_r.accum_r;
	assign O_CARRY = st_r.carry_act_r;
	assign O_ZERO = st_r.zero_act_r;
	assign O_CTX = st_r.ctx_r;
	assign O_MC_TICK = mc_tick_r;
	assign O_IN_RESET_FETCH = st_r.boot_r;
endmodule : cpr_core_state

// ===== hdl/cpr_pkg.sv
/*
 * Package for the core programmer-visible state: data-space addresses,
 * reset values, vectors, context and update-source encodings.
 * Assumes a single 50 MHz clock and an active-high asynchronous reset.
 */
// Contract
// - 8-bit accumulator, data address FFh
// - Pointer registers mapped at 80h and 81h
// - Short-direct registers mapped at 82h, 83h
// - 12-bit program counter, 4096 byte reach
// - PC loads: jump, branch, vector, pop, increment
// - Increment after fetch; branch via adder
// - Three carry/zero pairs, active one used
// - Enter irq/nmi pair; return restores previous
// - Pairs never cleared on context switch
// - Pair touched only in own context
// - Carry from arithmetic, bit test, rotate
// - Zero set when result equals zero
// - Reset starts in non-maskable context
// - Six-entry 12-bit LIFO, no pointer
// - Push shifts deeper, drops sixth, PC first
// - Pop moves first into PC, shifts up
// - Overflow keeps depth, oldest lost silently
// - Pop on empty stack: next instruction
// - Only PC pushed, no data registers
// - Machine cycle is clock divided by 13
// - Instructions take two, four, five cycles
// - Reset clears stack, PC from 0FFEh
package cpr_pkg;
	// ****************************************************************
	// Data-space addresses
	// ****************************************************************
	localparam logic [7:0] CPR_ADDR_PTR_FIRST = 8'h80;
	localparam logic [7:0] CPR_ADDR_PTR_SECOND = 8'h81;
	localparam logic [7:0] CPR_ADDR_SD_FIRST = 8'h82;
	localparam logic [7:0] CPR_ADDR_SD_SECOND = 8'h83;
	localparam logic [7:0] CPR_ADDR_ACCUM = 8'hFF;
	localparam logic [7:0] CPR_REG_RESET = 8'h00;

	// ****************************************************************
	// Program counter, vectors and stack
	// ****************************************************************
	localparam int CPR_PC_W = 12;
	localparam int CPR_STACK_DEPTH = 6;
	localparam logic [11:0] CPR_RESET_VECTOR = 12'hFFE;
	localparam logic [11:0] CPR_PC_RESET = 12'h000;
	localparam logic [2:0] CPR_LEVEL_RESET = 3'h0;

	// ****************************************************************
	// Timing: machine cycle is the core clock divided by 13
	// ****************************************************************
	localparam int CPR_MC_DIV = 13;
	localparam logic [3:0] CPR_MC_LAST = 4'(CPR_MC_DIV - 1);

	// ****************************************************************
	// Context and program-counter update sources
	// ****************************************************************
	typedef enum logic [2:0] {
		CPR_CTX_MAIN = 3'b001,
		CPR_CTX_IRQ = 3'b010,
		CPR_CTX_NMI = 3'b100
	} cpr_ctx_t;

	typedef enum logic [2:0] {
		CPR_PC_NEXT = 3'h0,
		CPR_PC_JUMP = 3'h1,
		CPR_PC_CALL = 3'h2,
		CPR_PC_BRANCH = 3'h3,
		CPR_PC_IRQ = 3'h4,
		CPR_PC_NMI = 3'h5,
		CPR_PC_SUB_EXIT = 3'h6,
		CPR_PC_INT_EXIT = 3'h7
	} cpr_pc_op_t;

	// Flag operation kinds
	localparam logic [1:0] CPR_FLG_NONE = 2'h0;
	localparam logic [1:0] CPR_FLG_ARITH = 2'h1;
	localparam logic [1:0] CPR_FLG_LOGIC = 2'h2;
	localparam logic [1:0] CPR_FLG_CARRY = 2'h3;
endpackage : cpr_pkg

// ===== hdl/cpr_mc_div.sv
/*
 * Machine-cycle divider: one-cycle enable pulse every thirteen clocks.
 * Assumes the core clock is the already divided internal clock.
 */
`timescale 1ns/1ns
module cpr_mc_div (
	input wire logic i_clk,
	input wire logic i_rst,
	output logic o_tick
);
	import cpr_pkg::*;

	typedef struct packed {
		logic [3:0] cnt_r;
		logic tick_r;
	} cpr_div_st_t;

	cpr_div_st_t st_r;
	cpr_div_st_t st_nxt;

	// ****************************************************************
	// Counter
	// ****************************************************************
	// Wrap at twelve so the pulse period is exactly thirteen
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick_r = (st_r.cnt_r == CPR_MC_LAST);
		if (st_r.cnt_r == CPR_MC_LAST) begin
			st_nxt.cnt_r = 4'h0;
		end else begin
			st_nxt.cnt_r = st_r.cnt_r + 4'h1;
		end
	end

	// Register the state
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_tick = st_r.tick_r;
endmodule : cpr_mc_div

// ===== hdl/cpr_ret_stack.sv
/*
 * Six-level return stack of 12-bit entries, a shift register with no
 * pointer. Assumes push and pop are never asserted together.
 */
`timescale 1ns/1ns
module cpr_ret_stack (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [11:0] i_data,
	output logic [11:0] o_top,
	output logic o_empty
);
	import cpr_pkg::*;

	typedef struct packed {
		logic [CPR_STACK_DEPTH-1:0][11:0] lvl_r;
		logic [2:0] used_r;
	} cpr_stk_st_t;

	cpr_stk_st_t st_r;
	cpr_stk_st_t st_nxt;

	// ****************************************************************
	// Shift logic
	// ****************************************************************
	// Only the return address is stored; data registers never enter
	always_comb begin
		st_nxt = st_r;
		if (i_push) begin
			st_nxt.lvl_r[0] = i_data;
			for (int i = 1; i < CPR_STACK_DEPTH; i++) begin
				st_nxt.lvl_r[i] = st_r.lvl_r[i-1];
			end
			// Depth saturates; oldest address drops with no flag
			if (st_r.used_r != 3'(CPR_STACK_DEPTH)) begin
				st_nxt.used_r = st_r.used_r + 3'h1;
			end
		end else if (i_pop) begin
			for (int i = 0; i < CPR_STACK_DEPTH - 1; i++) begin
				st_nxt.lvl_r[i] = st_r.lvl_r[i+1];
			end
			// Count holds at zero on an empty stack; entries still shift up
			if (st_r.used_r != 3'h0) begin
				st_nxt.used_r = st_r.used_r - 3'h1;
			end
		end
	end

	// Register the state; reset empties the stack
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_top = st_r.lvl_r[0];
	assign o_empty = (st_r.used_r == 3'h0);
endmodule : cpr_ret_stack

// ===== verif/cpr_prog_mem.sv
/*
 * Program memory model: the vector words the core fetches at reset and
 * on interrupt entry.
 * Assumes combinational reads and contents fixed when the bench is built.
 */
`timescale 1ns/1ns
module cpr_prog_mem #(
	parameter logic [11:0] RST_VEC = 12'h880,
	parameter logic [11:0] IRQ_VEC = 12'h3A0,
	parameter logic [11:0] NMI_VEC = 12'h5C4
) (
	input wire cpr_pkg::cpr_pc_op_t i_op,
	output logic [11:0] o_reset_vec,
	output logic [11:0] o_int_vec
);
	import cpr_pkg::*;
	// ****************************************************************
	// Vector reads
	// ****************************************************************
	// Word stored at 0FFEh, offered whenever the core may fetch it
	assign o_reset_vec = RST_VEC;
	// Off an entry the bus shows junk, so a stray use cannot pass
	assign o_int_vec = (i_op == CPR_PC_NMI) ? NMI_VEC :
		(i_op == CPR_PC_IRQ) ? IRQ_VEC : ~IRQ_VEC;
endmodule : cpr_prog_mem

// ===== verif/cpr_core_state_checker.sv
/*
 * Checker for cpr_core_state: relations between its ports over time.
 * Assumes a bind into the core and a single clock domain.
 */
`timescale 1ns/1ns
module cpr_core_state_checker (
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	input wire logic [7:0] I_DS_ADDR,
	input wire logic I_DS_WR,
	input wire logic [7:0] I_DS_WDATA,
	input wire logic [7:0] O_DS_RDATA,
	input wire logic O_DS_HIT,
	input wire logic [1:0] I_FLG_OP,
	input wire logic I_FLG_CARRY,
	input wire logic [7:0] I_FLG_RESULT,
	input wire logic [11:0] O_PC,
	input wire logic [7:0] O_ACCUM,
	input wire logic O_CARRY,
	input wire logic O_ZERO,
	input wire cpr_pkg::cpr_ctx_t O_CTX,
	input wire logic O_MC_TICK
);
	import cpr_pkg::*;
	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Everything sits on the core clock; reset masks all attempts
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (I_RESET);

	reset_state_a: assert property ($past(I_RESET) |->
		O_CTX == CPR_CTX_NMI && O_PC == CPR_RESET_VECTOR)
		else $error("state after reset wrong");
	hit_map_a: assert property (!$past(I_RESET) |->
		O_DS_HIT == ($past(I_DS_ADDR) inside
		{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF}))
		else $error("hit flag does not follow address");
	unmapped_zero_a: assert property (!O_DS_HIT |->
		O_DS_RDATA == 8'h00) else $error("unmapped read not zero");
	accum_write_a: assert property (I_DS_WR &&
		I_DS_ADDR == CPR_ADDR_ACCUM |=> O_ACCUM == $past(I_DS_WDATA))
		else $error("accumulator write lost");
	accum_read_a: assert property (O_DS_HIT && !$past(I_RESET) &&
		$past(I_DS_ADDR) == CPR_ADDR_ACCUM |->
		O_DS_RDATA == $past(O_ACCUM))
		else $error("accumulator read wrong");
	tick_period_a: assert property (O_MC_TICK |=>
		!O_MC_TICK [*8] ##1 !O_MC_TICK [*4] ##1 O_MC_TICK)
		else $error("machine cycle not thirteen clocks");
	pc_on_tick_a: assert property ($changed(O_PC) |-> O_MC_TICK)
		else $error("pc moved off a machine cycle");
	ctx_onehot_a: assert property ($onehot(O_CTX))
		else $error("context not one-hot");
	arith_flags_a: assert property (I_FLG_OP == CPR_FLG_ARITH |=>
		O_CTX != $past(O_CTX) || (O_CARRY == $past(I_FLG_CARRY) &&
		O_ZERO == ($past(I_FLG_RESULT) == 8'h00)))
		else $error("arithmetic flags wrong");
	logic_flag_a: assert property (I_FLG_OP == CPR_FLG_LOGIC |=>
		O_CTX != $past(O_CTX) || (O_CARRY == $past(O_CARRY) &&
		O_ZERO == ($past(I_FLG_RESULT) == 8'h00)))
		else $error("logic zero flag wrong");
endmodule : cpr_core_state_checker

bind cpr_core_state cpr_core_state_checker chk (
	.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_DS_ADDR(I_DS_ADDR),
	.I_DS_WR(I_DS_WR), .I_DS_WDATA(I_DS_WDATA),
	.O_DS_RDATA(O_DS_RDATA), .O_DS_HIT(O_DS_HIT), .I_FLG_OP(I_FLG_OP),
	.I_FLG_CARRY(I_FLG_CARRY), .I_FLG_RESULT(I_FLG_RESULT),
	.O_PC(O_PC), .O_ACCUM(O_ACCUM), .O_CARRY(O_CARRY), .O_ZERO(O_ZERO),
	.O_CTX(O_CTX), .O_MC_TICK(O_MC_TICK)
);

// ===== verif/tb.sv
/*
 * Self-checking bench for cpr_core_state with a program memory model.
 * Assumes a 50 MHz clock and inputs moved 1 ns after each rising edge.
 */
`timescale 1ns/1ns
`define CHK(got, want) begin \
	check_count++; \
	if ((got) !== (want)) begin \
		num_errors++; \
		$display("ERROR %0t: got %h expected %h", $time, got, want); \
	end \
end
module tb;
	import cpr_pkg::*;
	localparam logic [11:0] RST_VEC = 12'h880;
	localparam logic [11:0] IRQ_VEC = 12'h3A0;
	localparam logic [11:0] NMI_VEC = 12'h5C4;
	logic I_CLOCK = 0;
	logic I_RESET = 1;
	logic [7:0] ds_addr = 0, ds_wdata = 0, pc_off = 0, flg_res = 0;
	logic ds_wr = 0, pc_step = 0, pc_bw = 0, flg_c = 0;
	logic [1:0] flg_op = 0;
	cpr_pc_op_t pc_op_s = CPR_PC_NEXT;
	logic [11:0] pc_tgt = 0, rst_vec, int_vec, O_PC, exp_pc;
	logic [7:0] rdata, accum;
	logic hit, carry, zero, tick, fetch;
	cpr_ctx_t O_CTX, ectx, eprv;
	logic ec [8];
	logic ez [8];
	logic [11:0] stk [$];
	int num_errors = 0, check_count = 0, cyc = 0, seed = 23;
	cpr_pc_op_t ops [5] = '{CPR_PC_NEXT, CPR_PC_JUMP, CPR_PC_CALL,
		CPR_PC_BRANCH, CPR_PC_SUB_EXIT};

	cpr_prog_mem #(.RST_VEC(RST_VEC), .IRQ_VEC(IRQ_VEC),
		.NMI_VEC(NMI_VEC)) mem (.i_op(pc_op_s), .o_reset_vec(rst_vec),
		.o_int_vec(int_vec));
	cpr_core_state uut (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
		.I_DS_ADDR(ds_addr), .I_DS_WR(ds_wr), .I_DS_WDATA(ds_wdata),
		.O_DS_RDATA(rdata), .O_DS_HIT(hit), .I_PC_STEP(pc_step),
		.I_PC_OP(pc_op_s), .I_PC_TARGET(pc_tgt), .I_PC_VECTOR(int_vec),
		.I_PC_OFFSET(pc_off), .I_PC_BACKWARD(pc_bw),
		.I_RESET_VECTOR_DATA(rst_vec), .I_FLG_OP(flg_op),
		.I_FLG_CARRY(flg_c), .I_FLG_RESULT(flg_res), .O_PC(O_PC),
		.O_ACCUM(accum), .O_CARRY(carry), .O_ZERO(zero), .O_CTX(O_CTX),
		.O_MC_TICK(tick), .O_IN_RESET_FETCH(fetch));

	// ****************************************************************
	// Clock, watchdog and tasks
	// ****************************************************************
	always #10 I_CLOCK = ~I_CLOCK;
	// About 800 cycles are needed; the ceiling leaves ample margin
	always @(posedge I_CLOCK) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			test_done;
		end
	end

	task automatic test_done;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	// PC, context and active carry/zero pair against the bench model
	task automatic chk;
		`CHK(O_PC, exp_pc)
		`CHK(O_CTX, ectx)
		`CHK(carry, ec[ectx])
		`CHK(zero, ez[ectx])
	endtask : chk

	task automatic do_reset;
		I_RESET = 1;
		repeat (20) @(posedge I_CLOCK);
		#1 I_RESET = 0;
		exp_pc = CPR_RESET_VECTOR;
		ectx = CPR_CTX_NMI;
		eprv = CPR_CTX_MAIN;
		stk.delete();
		for (int i = 0; i < 8; i++) begin
			ec[i] = 0;
			ez[i] = 0;
		end
		chk;
		`CHK(fetch, 1'b1)
		// Tick register rises at edge 13; the vector lands one edge later
		repeat (14) @(posedge I_CLOCK);
		#1 exp_pc = RST_VEC;
		chk;
		`CHK(fetch, 1'b0)
		$display("reset test done");
	endtask : do_reset

	// Write, then read back on the following cycle
	task automatic ds_wr_rd(input logic [7:0] addr, input logic [7:0] dat);
		logic m;
		m = addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
		@(posedge I_CLOCK);
		#1 ds_addr = addr;
		ds_wr = 1;
		ds_wdata = dat;
		@(posedge I_CLOCK);
		#1 ds_wr = 0;
		@(posedge I_CLOCK);
		#1 `CHK(hit, m)
		`CHK(rdata, m ? dat : 8'h00)
		if (addr == 8'hFF) `CHK(accum, dat)
	endtask : ds_wr_rd

	task automatic flg(input logic [1:0] op, input logic c,
		input logic [7:0] r);
		@(posedge I_CLOCK);
		#1 flg_op = op;
		flg_c = c;
		flg_res = r;
		@(posedge I_CLOCK);
		#1 flg_op = 0;
		if (op == CPR_FLG_ARITH || op == CPR_FLG_CARRY) ec[ectx] = c;
		if (op == CPR_FLG_ARITH || op == CPR_FLG_LOGIC) ez[ectx] = r == 0;
		chk;
	endtask : flg

	// Step held for 13 clocks meets exactly one machine-cycle tick
	task automatic pc_op(input cpr_pc_op_t op, input logic [11:0] t,
		input logic bw);
		logic [11:0] p;
		p = exp_pc;
		@(posedge I_CLOCK);
		#1 pc_step = 1;
		pc_op_s = op;
		pc_tgt = t;
		pc_off = t[7:0];
		pc_bw = bw;
		repeat (13) @(posedge I_CLOCK);
		#1 pc_step = 0;
		case (op)
			CPR_PC_JUMP: exp_pc = t;
			CPR_PC_BRANCH: exp_pc = bw ? p - 12'(t[7:0]) : p + 12'(t[7:0]);
			CPR_PC_CALL, CPR_PC_IRQ, CPR_PC_NMI: begin
				stk.push_front(p);
				if (stk.size() > 6) stk.pop_back();
				exp_pc = op == CPR_PC_CALL ? t :
					(op == CPR_PC_IRQ ? IRQ_VEC : NMI_VEC);
			end
			CPR_PC_SUB_EXIT, CPR_PC_INT_EXIT:
				exp_pc = stk.size() > 0 ? stk.pop_front() : p + 12'h1;
			default: exp_pc = p + 12'h1;
		endcase
		if (op == CPR_PC_IRQ || op == CPR_PC_NMI) begin
			eprv = ectx;
			ectx = op == CPR_PC_IRQ ? CPR_CTX_IRQ : CPR_CTX_NMI;
		end
		if (op == CPR_PC_INT_EXIT) begin
			ectx = eprv;
			eprv = CPR_CTX_MAIN;
		end
		chk;
	endtask : pc_op

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [7:0] addrs [8];
		addrs = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h84, 8'h00, 8'hFE};
		do_reset;
		foreach (addrs[i]) ds_wr_rd(addrs[i], 8'($random(seed)));
		$display("register test done");
		// Distinct flag values per bank expose any bank mix-up
		flg(CPR_FLG_ARITH, 1'b0, 8'h00);
		pc_op(CPR_PC_INT_EXIT, 12'h000, 1'b0);
		flg(CPR_FLG_ARITH, 1'b1, 8'h00);
		flg(CPR_FLG_LOGIC, 1'b0, 8'h05);
		pc_op(CPR_PC_JUMP, 12'h345, 1'b0);
		pc_op(CPR_PC_IRQ, 12'h000, 1'b0);
		flg(CPR_FLG_ARITH, 1'b1, 8'h00);
		pc_op(CPR_PC_INT_EXIT, 12'h000, 1'b0);
		pc_op(CPR_PC_NMI, 12'h000, 1'b0);
		pc_op(CPR_PC_INT_EXIT, 12'h000, 1'b0);
		$display("context test done");
		pc_op(CPR_PC_JUMP, 12'hFFA, 1'b0);
		pc_op(CPR_PC_BRANCH, 12'h0FF, 1'b0);
		pc_op(CPR_PC_BRANCH, 12'h0FF, 1'b1);
		repeat (20) begin
			pc_op(ops[$unsigned($random(seed)) % 5], 12'($random(seed)),
				1'($random(seed)));
			flg(2'($random(seed)), 1'($random(seed)),
				8'($random(seed) % 3));
		end
		$display("random test done");
		// Seven calls overflow the six levels; eight exits underflow
		repeat (7) pc_op(CPR_PC_CALL, 12'($random(seed)), 1'b0);
		repeat (8) pc_op(CPR_PC_SUB_EXIT, 12'h000, 1'b0);
		$display("stack test done");
		pc_op(CPR_PC_CALL, 12'h123, 1'b0);
		do_reset;
		pc_op(CPR_PC_SUB_EXIT, 12'h000, 1'b0);
		$display("second reset test done");
		test_done;
	end
endmodule : tb
